// ==== verilog/maf_map.svh ====
// offsets, field positions, reset values and limits of the filter block
`ifndef MAF_MAP_SVH
`define MAF_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define MAF_ADDR_FUNC      5'h00
`define MAF_ADDR_CFG_CONCURRENT_MEASURE  5'h04
`define MAF_ADDR_CFG_CURR  5'h08
`define MAF_ADDR_CFG_VOLT  5'h0c
`define MAF_ADDR_STATUS    5'h10
`define MAF_ADDR_RESULT    5'h14

// ****************************************************************
// configuration and status word fields
// ****************************************************************
`define MAF_CFG_COUNT_LSB  0
`define MAF_CFG_COUNT_MSB  6
`define MAF_CFG_EN_BIT     8
`define MAF_CFG_KIND_BIT   12
`define MAF_STAT_BUSY_BIT  0
`define MAF_STAT_FULL_BIT  1

// ****************************************************************
// reset values and limits
// ****************************************************************
`define MAF_COUNT_RST      7'h0a
`define MAF_COUNT_MIN      7'h02
`define MAF_COUNT_MAX      7'h64
`define MAF_EN_RST         1'h1
`define MAF_DATA_W         24
`define MAF_CNT_W          7
`define MAF_FUNC_W         2
`define MAF_FUNC_SPARE     2'h3
`define MAF_NUM_FUNC       3

`endif

// ==== verilog/maf_pkg.sv ====
// types shared by the moving-average filter design
`include "maf_map.svh"
package maf_pkg;

  // selectable measurement functions
  typedef enum logic [`MAF_FUNC_W-1:0] {
    concurrent_measure = 2'b00,
    current_measure    = 2'b01,
    voltage_measure    = 2'b10
  } meas_func_t;

  // only the moving kind exists
  typedef enum logic {
    kind_moving = 1'b0
  } filter_kind_t;

  // per-function filter settings
  typedef struct packed {
    logic [`MAF_CNT_W-1:0] count;
    logic                  enable;
    filter_kind_t          filter_kind;
  } filter_cfg_t;

  // one reading on the stream
  typedef struct packed {
    logic signed [`MAF_DATA_W-1:0] value;
  } reading_t;

  // filter sequencer states
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_FILL   = 2'b01,
    S_UPDATE = 2'b10,
    S_DIV    = 2'b11
  } maf_state_t;

endpackage

// ==== verilog/avg_history_mem.sv ====
// history store for the averaging filter, registered read data
module avg_history_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 100,
  parameter int AW    = 7
) (
  // clocking
  input  wire logic             clk_sys,
  input  wire logic             clk_en,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // one write and one registered read per cycle
  always_ff @(posedge clk_sys)
  begin
    if (clk_en && wr_en)
      mem[wr_addr] <= wr_data;
    if (clk_en && rd_en)
      rd_data <= mem[rd_addr];
  end

endmodule

// ==== verilog/avg_divider.sv ====
// serial signed divide of the history sum by the filter count
module avg_divider #(
  parameter int SUM_W = 31,
  parameter int DIV_W = 7,
  parameter int Q_W   = 24
) (
  // clocking
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  // request
  input  wire logic                    start,
  input  wire logic signed [SUM_W-1:0] dividend,
  input  wire logic        [DIV_W-1:0] divisor,
  // answer
  output logic                         done,
  output logic signed      [Q_W-1:0]   quotient
);

  localparam int CW = $clog2(SUM_W + 1);

  logic [SUM_W-1:0] mag_r;
  logic [DIV_W-1:0] rem_r;
  logic [CW-1:0]    cnt_r;
  logic             busy_r;
  logic             neg_r;
  logic [DIV_W:0]   trial;
  logic             ge;
  logic [DIV_W:0]   diff;
  logic [Q_W-1:0]   qmag;

  // one restoring step per cycle
  assign trial = {rem_r, mag_r[SUM_W-1]};
  assign ge    = trial >= {1'b0, divisor};
  assign diff  = trial - {1'b0, divisor};
  assign qmag  = mag_r[Q_W-1:0];

  // truncates toward zero; result always fits as |avg| <= |reading|
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mag_r    <= '0;
      rem_r    <= '0;
      cnt_r    <= '0;
      busy_r   <= 1'b0;
      neg_r    <= 1'b0;
      done     <= 1'b0;
      quotient <= '0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (start)
      begin
        neg_r  <= dividend[SUM_W-1];
        mag_r  <= dividend[SUM_W-1] ? SUM_W'(-dividend) : dividend;
        rem_r  <= '0;
        cnt_r  <= CW'(SUM_W);
        busy_r <= 1'b1;
      end
      else if (busy_r && cnt_r != '0)
      begin
        rem_r <= ge ? diff[DIV_W-1:0] : trial[DIV_W-1:0];
        mag_r <= {mag_r[SUM_W-2:0], ge};
        cnt_r <= cnt_r - CW'(1);
      end
      else if (busy_r)
      begin
        busy_r   <= 1'b0;
        done     <= 1'b1;
        quotient <= neg_r ? Q_W'(-qmag) : qmag;
      end
    end
  end

endmodule

// ==== verilog/maf_filter.sv ====
// measurement function select and per-function moving-average filter
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`include "maf_map.svh"

// Behaviour
// - one active function, concurrent after reset
// - function register reads back active function
// - separate filter settings for each function
// - count 2..100, default 10, others refused
// - history length equals programmed count
// - enable bit: 1 on, 0 off, default on
// - enabled: output is average of readings
// - filter kind only moving, default moving
// - every filtered reading enters history in FIFO order
// - oldest history entry dropped per reading
// - one fresh average per new reading
// - first reading copied into every history slot
module maf_filter #(
  parameter int DATA_W    = `MAF_DATA_W,
  parameter int MAX_COUNT = 100
) (
  // clocking and control
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                clk_en,
  // avalon-mm slave
  input  wire logic [4:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  // raw readings in
  input  wire maf_pkg::reading_t   sample_in,
  input  wire logic                sample_valid,
  output logic                     sample_ready,
  // readings out, raw or averaged
  output maf_pkg::reading_t        reading_out,
  output logic                     reading_valid
);

  localparam int AW    = `MAF_CNT_W;
  localparam int SUM_W = DATA_W + AW;

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // configuration word as seen on the bus
  function automatic logic [31:0] cfg_word(input maf_pkg::filter_cfg_t c);
    logic [31:0] w;
    w = '0;
    w[`MAF_CFG_COUNT_MSB:`MAF_CFG_COUNT_LSB] = c.count;
    w[`MAF_CFG_EN_BIT]   = c.enable;
    w[`MAF_CFG_KIND_BIT] = c.filter_kind;
    return w;
  endfunction

  // next history slot, wrapping at the programmed count
  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p,
                                             input logic [AW-1:0] n);
    return (p == AW'(n - `MAF_COUNT_MIN + 7'h01)) ? '0 : AW'(p + 7'h01);
  endfunction

  // widen a reading to the sum width
  function automatic logic signed [SUM_W-1:0] widen(
    input logic signed [DATA_W-1:0] v);
    return SUM_W'(v);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  maf_pkg::meas_func_t         func_r;
  maf_pkg::filter_cfg_t        cfg_r [`MAF_NUM_FUNC];
  maf_pkg::maf_state_t         state_r;
  logic [AW-1:0]               ptr_r;
  logic [AW-1:0]               fill_ptr_r;
  logic                        hist_full_r;
  logic signed [SUM_W-1:0]     sum_r;
  logic signed [DATA_W-1:0]    new_r;
  logic signed [DATA_W-1:0]    result_r;
  logic                        div_start_r;
  // count latched per reading, so a mid-flight settings write cannot
  // change the divisor or the fill length under a running reading
  logic [AW-1:0]               run_count_r;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic                        bus_req;
  logic                        commit;
  logic                        wr_commit;
  logic [AW-1:0]               wr_count;
  logic                        wr_en_bit;
  logic                        wr_kind_bit;
  logic                        wr_cfg_ok;
  logic [1:0]                  wr_cfg_idx;
  logic                        wr_cfg_hit;
  logic                        wr_func_hit;
  logic                        wr_func_ok;
  logic [31:0]                 rd_mux;
  logic [31:0]                 status_word;
  logic                        restart;

  // an access commits only on the edge that sees waitrequest low
  assign bus_req     = read | write;
  assign commit      = bus_req & ~waitrequest;
  assign wr_commit   = commit & write;
  // configuration fields as they stand in the write data
  assign wr_count    = writedata[`MAF_CFG_COUNT_MSB:`MAF_CFG_COUNT_LSB];
  assign wr_en_bit   = writedata[`MAF_CFG_EN_BIT];
  assign wr_kind_bit = writedata[`MAF_CFG_KIND_BIT];
  // counts outside the legal window or unknown kinds leave cfg unchanged
  assign wr_cfg_ok   = (wr_count >= `MAF_COUNT_MIN)
                     & (wr_count <= `MAF_COUNT_MAX)
                     & (wr_kind_bit == maf_pkg::kind_moving);
  assign wr_cfg_hit  = wr_commit & ((address == `MAF_ADDR_CFG_CONCURRENT_MEASURE)
                     | (address == `MAF_ADDR_CFG_CURR)
                     | (address == `MAF_ADDR_CFG_VOLT));
  assign wr_cfg_idx  = (address == `MAF_ADDR_CFG_CONCURRENT_MEASURE) ? 2'h0 :
                       (address == `MAF_ADDR_CFG_CURR) ? 2'h1 : 2'h2;
  assign wr_func_hit = wr_commit & (address == `MAF_ADDR_FUNC);
  // the spare code 3 names no function and is refused
  assign wr_func_ok  = writedata[1:0] != `MAF_FUNC_SPARE;

  // busy while a reading is in flight, full once history is primed
  assign status_word = {30'h0000_0000, hist_full_r,
                        state_r != maf_pkg::S_IDLE};

  // unmapped offsets read as zero
  assign rd_mux =
    (address == `MAF_ADDR_FUNC)     ? {30'h0000_0000, func_r} :
    (address == `MAF_ADDR_CFG_CONCURRENT_MEASURE) ? cfg_word(cfg_r[0]) :
    (address == `MAF_ADDR_CFG_CURR) ? cfg_word(cfg_r[1]) :
    (address == `MAF_ADDR_CFG_VOLT) ? cfg_word(cfg_r[2]) :
    (address == `MAF_ADDR_STATUS)   ? status_word :
    (address == `MAF_ADDR_RESULT)   ? 32'(unsigned'(result_r)) :
                                      32'h0000_0000;

  // a new function, or any change to the active settings, empties history
  assign restart = (wr_func_hit & wr_func_ok
                    & (writedata[1:0] != func_r))
                 | (wr_cfg_hit & wr_cfg_ok
                    & (wr_cfg_idx == func_r));

  // ****************************************************************
  // bus handshake
  // ****************************************************************

  // waitrequest drops one cycle after the request; the edge that sees
  // it low is the only one that commits, so back to back costs two
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      waitrequest <= 1'b1;
      readdata    <= '0;
    end
    else if (clk_en)
    begin
      waitrequest <= ~(bus_req & waitrequest);
      if (read & waitrequest)
        readdata <= rd_mux;
    end
  end

  // function select and per-function settings
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      func_r <= maf_pkg::concurrent_measure;
      for (int i = 0; i < `MAF_NUM_FUNC; i++)
      begin
        cfg_r[i].count       <= `MAF_COUNT_RST;
        cfg_r[i].enable      <= `MAF_EN_RST;
        cfg_r[i].filter_kind <= maf_pkg::kind_moving;
      end
    end
    else if (clk_en)
    begin
      if (wr_func_hit && wr_func_ok)
        func_r <= maf_pkg::meas_func_t'(writedata[1:0]);
      if (wr_cfg_hit && wr_cfg_ok)
      begin
        // only the addressed function's slot changes
        cfg_r[wr_cfg_idx].count       <= wr_count;
        cfg_r[wr_cfg_idx].enable      <= wr_en_bit;
        cfg_r[wr_cfg_idx].filter_kind <= maf_pkg::kind_moving;
      end
    end
  end

  // ****************************************************************
  // filter datapath
  // ****************************************************************
  maf_pkg::filter_cfg_t        act_cfg;
  logic [AW-1:0]               act_count;
  logic                        accept;
  logic                        mem_wr_en;
  logic [AW-1:0]               mem_wr_addr;
  logic [DATA_W-1:0]           mem_rd_data;
  logic                        div_done;
  logic signed [DATA_W-1:0]    div_q;
  logic signed [SUM_W-1:0]     fill_sum;
  logic signed [SUM_W-1:0]     slide_sum;
  logic                        fill_last;

  // settings of the active function steer the datapath
  assign act_cfg   = cfg_r[func_r];
  assign act_count = act_cfg.count;
  assign accept    = sample_valid & sample_ready;
  assign mem_wr_en = (state_r == maf_pkg::S_FILL)
                   | (state_r == maf_pkg::S_UPDATE);
  assign mem_wr_addr = (state_r == maf_pkg::S_FILL) ? fill_ptr_r : ptr_r;
  assign fill_last = fill_ptr_r == AW'(run_count_r - 7'h01);
  // first reading stands in every slot, so the sum is count copies
  assign fill_sum  = SUM_W'(widen(new_r) * $signed({1'b0, run_count_r}));
  // drop the oldest slot, add the newest
  assign slide_sum = sum_r - widen(mem_rd_data) + widen(new_r);

  // history store: written in fill and update, read on accept
  avg_history_mem #(
    .WIDTH (DATA_W),
    .DEPTH (MAX_COUNT),
    .AW    (AW)
  ) u_hist (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (new_r),
    .rd_en   (accept),
    .rd_addr (ptr_r),
    .rd_data (mem_rd_data)
  );

  // divider sees the latched count, never the live setting
  avg_divider #(
    .SUM_W (SUM_W),
    .DIV_W (AW),
    .Q_W   (DATA_W)
  ) u_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clk_en   (clk_en),
    .start    (div_start_r),
    .dividend (sum_r),
    .divisor  (run_count_r),
    .done     (div_done),
    .quotient (div_q)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************

  // one reading in flight; ready stays low until its answer leaves
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r       <= maf_pkg::S_IDLE;
      ptr_r         <= '0;
      fill_ptr_r    <= '0;
      hist_full_r   <= 1'b0;
      sum_r         <= '0;
      new_r         <= '0;
      result_r      <= '0;
      div_start_r   <= 1'b0;
      run_count_r   <= '0;
      sample_ready  <= 1'b0;
      reading_out   <= '0;
      reading_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      reading_valid <= 1'b0;
      div_start_r   <= 1'b0;
      unique case (state_r)
        maf_pkg::S_IDLE:
        begin
          // ready stays high while idle; a filtered reading drops it
          sample_ready <= 1'b1;
          if (accept && !act_cfg.enable)
          begin
            // filter off: raw reading passes straight through
            reading_out.value <= sample_in.value;
            result_r          <= sample_in.value;
            reading_valid     <= 1'b1;
          end
          else if (accept)
          begin
            new_r        <= sample_in.value;
            run_count_r  <= act_count;
            sample_ready <= 1'b0;
            fill_ptr_r   <= '0;
            state_r      <= (hist_full_r && !restart)
                          ? maf_pkg::S_UPDATE : maf_pkg::S_FILL;
          end
        end
        maf_pkg::S_FILL:
        begin
          // one slot per cycle, so priming takes count cycles
          fill_ptr_r <= AW'(fill_ptr_r + 7'h01);
          if (fill_last)
          begin
            sum_r       <= fill_sum;
            ptr_r       <= '0;
            hist_full_r <= 1'b1;
            div_start_r <= 1'b1;
            state_r     <= maf_pkg::S_DIV;
          end
        end
        maf_pkg::S_UPDATE:
        begin
          // slot at ptr held the oldest reading; new one takes it
          sum_r       <= slide_sum;
          ptr_r       <= wrap_inc(ptr_r, run_count_r);
          div_start_r <= 1'b1;
          state_r     <= maf_pkg::S_DIV;
        end
        maf_pkg::S_DIV:
        begin
          // ready returns with the answer: one reading in flight
          if (div_done)
          begin
            reading_out.value <= div_q;
            result_r          <= div_q;
            reading_valid     <= 1'b1;
            sample_ready      <= 1'b1;
            state_r           <= maf_pkg::S_IDLE;
          end
        end
      endcase
      // a settings change mid-flight still finishes the reading; the next one
      // starts a fresh history unless the change lands in fill before its last slot
      if (restart)
        hist_full_r <= 1'b0;
    end
  end

endmodule

// ==== bench/maf_filter_asserts.sv ====
// concurrent checks on the ports of the moving-average filter block
module maf_filter_asserts #(
  parameter int MAX_COUNT = 100
) (
  // clocking and control
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              clk_en,
  // register bus
  input wire logic [4:0]        address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       writedata,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  // reading stream
  input wire maf_pkg::reading_t sample_in,
  input wire logic              sample_valid,
  input wire logic              sample_ready,
  input wire maf_pkg::reading_t reading_out,
  input wire logic              reading_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // helper state
  // ****************************************************************
  logic [1:0] func_r;
  logic [7:0] owed_r;
  wire        accept   = sample_valid && sample_ready;
  wire        fetch    = read && !waitrequest;
  wire        func_ok  = write && !waitrequest && address == 5'h00 &&
                         writedata[1:0] != 2'h3;
  wire [7:0]  owed_nxt = owed_r + 8'(accept) - 8'(reading_valid);

  // shadow of the active function and of readings still owed
  always_ff @(posedge clk_sys)
  begin
    func_r <= rst ? 2'h0 : (func_ok ? writedata[1:0] : func_r);
    owed_r <= rst ? 8'h00 : owed_nxt;
  end

  // ****************************************************************
  // bus and stream properties
  // ****************************************************************
  sequence bus_wait;
    (read || write) && waitrequest;
  endsequence
  sequence bus_answer;
    bus_wait ##1 !waitrequest;
  endsequence

  chk_wait_one: assert property (bus_wait |=> !waitrequest)
    else $error("bus access not answered after one wait cycle");
  chk_wait_single: assert property (bus_answer |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_wait_cause: assert property (!waitrequest |-> $past(read || write))
    else $error("waitrequest dropped without a request");
  chk_unmapped_zero: assert property (fetch && address >= 5'h18 |->
    readdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
  chk_func_read: assert property (fetch && address == 5'h00 |->
    readdata == {30'h0, func_r})
    else $error("function register read differs from selection");
  chk_out_hold: assert property (!reading_valid |-> $stable(reading_out))
    else $error("output reading changed without valid");
  chk_accept_out: assert property (accept |-> ##[1:300] reading_valid)
    else $error("accepted reading produced no output");
  chk_no_spurious: assert property (reading_valid |-> owed_r != 8'h00)
    else $error("output reading without an accepted input");
  chk_freeze_hold: assert property (!clk_en |=> $stable(reading_out) &&
    $stable(reading_valid) && $stable(sample_ready) &&
    $stable(waitrequest) && $stable(readdata))
    else $error("outputs moved while the clock enable was low");
endmodule

// ==== bench/raw_source.sv ====
// far-side model: acquisition path handing raw readings to the filter
module raw_source (
  // clocking
  input  wire logic         clk_sys,
  // stream towards the filter
  output maf_pkg::reading_t sample_in,
  output logic              sample_valid,
  input  wire logic         sample_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle lines at time zero
  initial
  begin
    sample_valid = 1'b0;
    sample_in    = '0;
  end

  // hold a reading until taken; the inverse afterwards exposes late capture
  task automatic send(input logic signed [23:0] v, input int slow);
    repeat (slow) @(posedge clk_sys);
    @(posedge clk_sys);
    sample_valid    <= 1'b1;
    sample_in.value <= v;
    do @(posedge clk_sys); while (sample_ready !== 1'b1);
    sample_valid    <= 1'b0;
    sample_in.value <= ~v;
  endtask
endmodule

// ==== bench/maf_filter_bench.sv ====
// self-checking bench for the measurement moving-average filter
module maf_filter_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              clk_en = 1'b1;
  logic [4:0]        address = 5'h00;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [31:0]       writedata = 32'h0000_0000;
  logic [31:0]       readdata;
  logic              waitrequest;
  maf_pkg::reading_t sample_in;
  logic              sample_valid;
  logic              sample_ready;
  maf_pkg::reading_t reading_out;
  logic              reading_valid;
  int                err_count = 0;
  int                comparisons = 0;
  longint            hist[$];
  int                cnts[4] = '{2, 7, 100, 2};
  logic [31:0]       bad[3] = '{32'h0000_0101, 32'h0000_0165, 32'h0000_110a};

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  maf_filter u_dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sample_in(sample_in), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .reading_out(reading_out),
    .reading_valid(reading_valid)
  );

  raw_source u_src (
    .clk_sys(clk_sys), .sample_in(sample_in),
    .sample_valid(sample_valid), .sample_ready(sample_ready)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one avalon access; request held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    // no latency assumed; only the watchdog ends a hung wait
    do
      @(posedge clk_sys);
    while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  // one reading through the filter against the reference history
  task automatic push(input int n, input logic en);
    logic signed [23:0] v;
    logic [23:0]        e;
    longint             s;
    int                 k;
    int                 seen;
    v = 24'($urandom);
    if (en && hist.size() == 0)
      repeat (n) hist.push_back(longint'(v));
    else if (en)
    begin
      void'(hist.pop_front());
      hist.push_back(longint'(v));
    end
    s = 0;
    foreach (hist[i])
      s += hist[i];
    e = en ? 24'(s / n) : v;
    u_src.send(v, $urandom % 4);
    // freeze the block mid-reading when filtering; no answer may leave meanwhile
    seen = 0;
    if (en)
    begin
      clk_en <= 1'b0;
      repeat (100)
      begin
        @(negedge clk_sys);
        seen += int'(reading_valid === 1'b1);
      end
      @(posedge clk_sys);
      clk_en <= 1'b1;
    end
    check(32'(seen), 32'h0);
    for (k = 0; k < 400; k++)
    begin
      @(negedge clk_sys);
      if (reading_valid === 1'b1)
        break;
    end
    check(32'(k < 400), 32'h1);
    check({8'h0, reading_out.value}, {8'h0, e});
    rd_chk(5'h14, {8'h0, e});
  endtask

  // watchdog sized well above the longest expected run
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    test_done();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(32'h3e69_f6e4));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(5'h00, 32'h0000_0000);
    for (int i = 1; i < 4; i++)
      rd_chk(5'(4 * i), 32'h0000_010a);
    for (int i = 0; i < 3; i++)
    begin
      wr(5'h00, 32'(i));
      rd_chk(5'h00, 32'(i));
    end
    wr(5'h00, 32'h0000_0003);
    rd_chk(5'h00, 32'h0000_0002);
    wr(5'h00, 32'h0000_0000);
    wr(5'h08, 32'h0000_0005);
    rd_chk(5'h08, 32'h0000_0005);
    rd_chk(5'h04, 32'h0000_010a);
    rd_chk(5'h0c, 32'h0000_010a);
    foreach (bad[i])
    begin
      wr(5'h04, bad[i]);
      rd_chk(5'h04, 32'h0000_010a);
    end
    rd_chk(5'h18, 32'h0000_0000);
    // random count among the table; each legal write empties history
    cnts[3] = 2 + int'($urandom % 99);
    foreach (cnts[j])
    begin
      wr(5'h04, 32'h0000_0100 | 32'(cnts[j]));
      rd_chk(5'h04, 32'h0000_0100 | 32'(cnts[j]));
      hist.delete();
      repeat (10) push(cnts[j], 1'b1);
      rd_chk(5'h10, 32'h0000_0002);
    end
    // averaging off: raw readings pass through
    wr(5'h04, 32'h0000_0003);
    rd_chk(5'h04, 32'h0000_0003);
    repeat (4) push(3, 1'b0);
    rd_chk(5'h10, 32'h0000_0000);
    // a second reset must bring the function and the concurrent settings back to their defaults
    wr(5'h00, 32'h0000_0001);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(5'h00, 32'h0000_0000);
    rd_chk(5'h04, 32'h0000_010a);
    test_done();
  end
endmodule

bind maf_filter maf_filter_asserts #(.MAX_COUNT(MAX_COUNT)) u_chk (
  .clk_sys, .rst, .clk_en, .address, .read, .write, .writedata,
  .readdata, .waitrequest, .sample_in, .sample_valid, .sample_ready,
  .reading_out, .reading_valid
);
